// File: mrf_pkg.sv
// mrf_pkg: constants, field positions and types for the mode register block
// assumes a single core clock; no other file in the design needs more
package mrf_pkg;
   localparam int          MR_W        = 22;
   localparam logic [2:0]  SEL_MR4     = 3'h4;
   localparam logic [2:0]  SEL_MR5     = 3'h5;
   localparam logic [2:0]  SEL_DNU     = 3'h7;
   // fifth mode register fields
   localparam int          P5_RINV     = 12;
   localparam int          P5_WINV     = 11;
   localparam int          P5_WMASK    = 10;
   localparam int          P5_PERSIST  = 9;
   localparam int          P5_PARK_LO  = 6;
   localparam int          P5_ODTBUF   = 5;
   localparam int          P5_PARSTAT  = 4;
   localparam int          P5_CRCSTAT  = 3;
   localparam int          P5_PL_LO    = 0;
   // fourth mode register fields
   localparam int          P4_CAL_LO   = 6;
   localparam int          P4_VREF     = 4;
   localparam int          P4_TCR      = 3;
   localparam int          P4_RANGE    = 2;
   localparam int          P4_MPS      = 1;
   // reset values and writable masks
   localparam logic [21:0] MR5_RST     = 22'h000000;
   localparam logic [21:0] MR5_WR_MASK = 22'h001FE7;
   localparam logic [21:0] MR4_RST     = 22'h000000;
   localparam logic [21:0] MR4_WR_MASK = 22'h0001DE;
   // refresh commands per internal refresh while cool
   localparam logic [1:0]  TCR_RATIO   = 2'h2;
   // parked termination in ohms, indexed by code
   localparam logic [7:0]  PARK_OHM [8] = '{8'h00, 8'h3C, 8'h78, 8'h28,
                                            8'hF0, 8'h30, 8'h50, 8'h22};

   typedef struct packed {
      logic       actN;
      logic       rasN;
      logic       casN;
      logic       weN;
      logic [1:0] bg;
      logic [1:0] ba;
      logic       a17;
      logic [13:0] addr;
   } mrf_cmd_s;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_MPS = 2'b10
   } mrf_state_e;
endpackage

// File: mrf_mode_regs.sv
// mrf_mode_regs: fifth and fourth mode registers of the memory device
// assumes command pins are synchronous to core_clk, sampled on every rising edge
//
// Notes on behaviour
// - cool refresh skips external refreshes at fixed ratio
// - refresh range bit picks normal or extended
// - delayed command capture after chip select edge
// - max power saving ignores all but exit
// - select 101 writes fifth register; 111 unused
// - bits 12 and 11 enable read/write inversion
// - multipurpose readout never inverted
// - bit 10 masks writes only
// - parked termination code to ohms table
// - bit 5 turns termination buffer off in power-down
// - bit 4 parity error, bit 3 crc error
// - error bits sticky until cleared by mode set
// - parity latency 0,4,5,6 clocks, rest reserved
// - non-persistent mode stops checking after an error
// - parity covers command and address, not controls
`timescale 1ns/1ps
module mrf_mode_regs
   import mrf_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       csN,
   input  wire logic       cke,
   input  wire mrf_cmd_s   cmdPins,
   input  wire logic       parityIn,
   input  wire logic       crcErr,
   input  wire logic       mprRead,
   input  wire logic       refreshReq,
   input  wire logic       coolTemp,
   output logic [MR_W-1:0] mr5Value,
   output logic [MR_W-1:0] mr4Value,
   output logic            cmdAccept,
   output mrf_cmd_s        cmdOut,
   output logic            parityErr,
   output logic            readInvEn,
   output logic            writeInvEn,
   output logic            writeMaskEn,
   output logic [7:0]      parkOhm,
   output logic            odtBufOffPd,
   output logic [2:0]      parLatClk,
   output logic [3:0]      calClk,
   output logic            tcrEn,
   output logic            tcrExtended,
   output logic            vrefMon,
   output logic            maxPowerSave,
   output logic            refreshDo
);
   mrf_state_e       state_q, state_d;
   logic [MR_W-1:0]  mr5_q, mr5_d, mr4_q, mr4_d;
   logic [7:0]       csHist_q, csHist_d;
   logic             cke_q, cke_d;
   logic [1:0]       skip_q, skip_d;
   logic [3:0]       calN;
   logic             strobe, chkOn, parFail, isMrs, wr5, wr4, mpsExit;
   logic [2:0]       sel;
   logic [MR_W-1:0]  word;
   logic             acc_d, perr_d, rinv_d, ref_d;
   logic [7:0]       ohm_d;
   logic [2:0]       pl_d;
   logic [3:0]       cal_d;

   default clocking mrfClk @(posedge core_clk);
   endclocking
   default disable iff (srst);

   always_comb begin
      calN     = 4'h0;
      strobe   = 1'b0;
      sel      = {cmdPins.bg[0], cmdPins.ba};
      word     = {cmdPins.bg, cmdPins.ba, cmdPins.a17, 3'h0,
                  cmdPins.addr};
      case (mr4_q[P4_CAL_LO +: 3])
         3'h1:    calN = 4'h3;
         3'h2:    calN = 4'h4;
         3'h3:    calN = 4'h5;
         3'h4:    calN = 4'h6;
         3'h5:    calN = 4'h8;
         default: calN = 4'h0;
      endcase
      // history bit n-1 holds the chip select seen n cycles ago
      if (calN == 4'h0) begin
         strobe = ~csN;
      end else begin
         strobe = csHist_q[3'(calN - 4'h1)];
      end
      // a checked command is dropped, not executed, on a parity miss
      chkOn   = (mr5_q[P5_PL_LO +: 3] != 3'h0) &&
                (mr5_q[P5_PERSIST] || !mr5_q[P5_PARSTAT]);
      parFail = strobe && chkOn && (state_q == ST_RUN) &&
                (^{cmdPins, parityIn});
      isMrs   = strobe && !parFail && (state_q == ST_RUN) && cmdPins.actN &&
                !cmdPins.rasN && !cmdPins.casN && !cmdPins.weN;
      wr5     = isMrs && (sel == SEL_MR5);
      wr4     = isMrs && (sel == SEL_MR4);
      mpsExit = (state_q == ST_MPS) && !cke_q && cke;
   end

   always_comb begin
      csHist_d = {csHist_q[6:0], ~csN};
      // new latency: drop old selects so none is replayed (in-flight lost)
      if (wr4 && (word[P4_CAL_LO +: 3] != mr4_q[P4_CAL_LO +: 3])) begin
         csHist_d = 8'h00;
      end
      cke_d    = cke;
      state_d  = state_q;
      mr4_d    = mr4_q;
      mr5_d    = mr5_q;
      skip_d   = skip_q;
      ref_d    = 1'b0;
      // reserved and select bits are never stored
      if (wr5) begin
         mr5_d = (mr5_q & ~MR5_WR_MASK) |
                 (word & MR5_WR_MASK);
         mr5_d[P5_PARSTAT] = mr5_q[P5_PARSTAT] & word[P5_PARSTAT];
         mr5_d[P5_CRCSTAT] = mr5_q[P5_CRCSTAT] & word[P5_CRCSTAT];
      end
      // set wins over a clear in the same cycle
      if (parFail) begin
         mr5_d[P5_PARSTAT] = 1'b1;
      end
      if (crcErr) begin
         mr5_d[P5_CRCSTAT] = 1'b1;
      end
      if (wr4) begin
         mr4_d = (mr4_q & ~MR4_WR_MASK) | (word & MR4_WR_MASK);
      end
      case (state_q)
         ST_RUN: begin
            if (mr4_d[P4_MPS]) begin
               state_d = ST_MPS;
            end
            if (refreshReq) begin
               if (mr4_q[P4_TCR] && coolTemp) begin
                  ref_d  = (skip_q == 2'h0);
                  skip_d = (skip_q == TCR_RATIO - 2'h1) ? 2'h0 :
                           skip_q + 2'h1;
               end else begin
                  ref_d  = 1'b1;
               end
            end
         end
         ST_MPS: begin
            // only the exit is honoured here; reset still acts
            if (mpsExit) begin
               state_d = ST_RUN;
               mr4_d[P4_MPS] = 1'b0;
            end
         end
         default: state_d = ST_RUN;
      endcase
      acc_d  = strobe && !parFail && (state_q == ST_RUN);
      perr_d = parFail;
      // inversion is suppressed for readout, read masking does not exist
      rinv_d = mr5_d[P5_RINV] && !mprRead;
      ohm_d  = PARK_OHM[mr5_d[P5_PARK_LO +: 3]];
      pl_d   = 3'h0;
      case (mr5_d[P5_PL_LO +: 3])
         3'h1:    pl_d = 3'h4;
         3'h2:    pl_d = 3'h5;
         3'h3:    pl_d = 3'h6;
         default: pl_d = 3'h0;
      endcase
      // the latency output follows the register in the cycle it is written
      case (mr4_d[P4_CAL_LO +: 3])
         3'h1:    cal_d = 4'h3;
         3'h2:    cal_d = 4'h4;
         3'h3:    cal_d = 4'h5;
         3'h4:    cal_d = 4'h6;
         3'h5:    cal_d = 4'h8;
         default: cal_d = 4'h0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q      <= ST_RUN;
         mr5_q        <= MR5_RST;
         mr4_q        <= MR4_RST;
         csHist_q     <= 8'h00;
         cke_q        <= 1'b0;
         skip_q       <= 2'h0;
         cmdAccept    <= 1'b0;
         cmdOut       <= '0;
         parityErr    <= 1'b0;
         readInvEn    <= 1'b0;
         writeInvEn   <= 1'b0;
         writeMaskEn  <= 1'b0;
         parkOhm      <= 8'h00;
         odtBufOffPd  <= 1'b0;
         parLatClk    <= 3'h0;
         calClk       <= 4'h0;
         tcrEn        <= 1'b0;
         tcrExtended  <= 1'b0;
         vrefMon      <= 1'b0;
         maxPowerSave <= 1'b0;
         refreshDo    <= 1'b0;
      end else begin
         state_q      <= state_d;
         mr5_q        <= mr5_d;
         mr4_q        <= mr4_d;
         csHist_q     <= csHist_d;
         cke_q        <= cke_d;
         skip_q       <= skip_d;
         cmdAccept    <= acc_d;
         cmdOut       <= cmdPins;
         parityErr    <= perr_d;
         readInvEn    <= rinv_d;
         writeInvEn   <= mr5_d[P5_WINV];
         writeMaskEn  <= mr5_d[P5_WMASK];
         parkOhm      <= ohm_d;
         odtBufOffPd  <= mr5_d[P5_ODTBUF];
         parLatClk    <= pl_d;
         calClk       <= cal_d;
         tcrEn        <= mr4_d[P4_TCR];
         tcrExtended  <= mr4_d[P4_RANGE];
         vrefMon      <= mr4_d[P4_VREF];
         maxPowerSave <= state_d == ST_MPS;
         refreshDo    <= ref_d;
      end
   end

   assign mr5Value = mr5_q;
   assign mr4Value = mr4_q;

   mprNoInv_a: assert property (
      mprRead |=> !readInvEn)
      else $error("inverted readout");
   parSet_a: assert property (
      parFail |=> mr5_q[P5_PARSTAT] && parityErr)
      else $error("parity status not set");
   errSticky_a: assert property (
      mr5_q[P5_CRCSTAT] && !(wr5 && !word[P5_CRCSTAT]) |=> mr5_q[P5_CRCSTAT])
      else $error("crc status lost");
   calFour_a: assert property (
      (mr4_q[8:6] == 3'h2) && (mr5_q[2:0] == 3'h0) && !mr4_q[P4_MPS] &&
      (state_q == ST_RUN) && !csN ##1 (mr4_q[8:6] == 3'h2) [*3]
      |-> ##2 cmdAccept)
      else $error("delayed capture missed");
   mpsIgnore_a: assert property (
      state_q == ST_MPS |=> !cmdAccept)
      else $error("command taken in max power saving");
   persistOff_a: assert property (
      mr5_q[P5_PARSTAT] && !mr5_q[P5_PERSIST] |-> !parFail)
      else $error("checking after error");
   parkTable_a: assert property (
      mr5_d[8:6] == 3'h4 |=> parkOhm == 8'hF0)
      else $error("park value wrong");
   tcrSkip_a: assert property (
      refreshReq && (state_q == ST_RUN) && mr4_q[P4_TCR] && coolTemp &&
      (skip_q == 2'h1) |=> !refreshDo)
      else $error("refresh not skipped");
   mr5Load_a: assert property (
      wr5 |=> (mr5_q[12:5] == $past(word[12:5])) && (mr5_q[21:13] == 9'h000))
      else $error("fifth register not loaded");
   otherSel_a: assert property (
      isMrs && (sel != SEL_MR5) |=> $stable(mr5_q[12:5]))
      else $error("foreign select wrote register");
   plMap_a: assert property (
      mr5_d[2:0] == 3'h2 |=> parLatClk == 3'h5)
      else $error("parity latency wrong");

   calCmd_c: cover property ((calN == 4'h8) && strobe ##1 cmdAccept);
   parErr_c: cover property (parFail);
   mpsExit_c: cover property (mpsExit);
   tcrSkip_c: cover property (
      refreshReq && mr4_q[P4_TCR] && coolTemp ##1 !refreshDo);
endmodule

// File: mrf_ctrl_model.sv
// mrf_ctrl_model: controller side, issues mode set commands on request
// assumes go is a one-cycle request launched just after a rising edge
`timescale 1ns/1ps
module mrf_ctrl_model
   import mrf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        go,
   input  wire logic [21:0] word,
   input  wire logic        badPar,
   output logic             csN = 1'b1,
   output mrf_cmd_s         cmdPins = '0,
   output logic             parityIn = 1'b0
);
   logic [3:0] hold = 4'h0;
   always_ff @(posedge core_clk) begin
      csN <= !go;
      if (go) begin
         // pins held long enough for the largest command delay
         hold <= 4'h9;
         cmdPins <= {1'b1, 3'b000, word[21:17], word[13:0]};
         parityIn <= ^{1'b1, word[21:17], word[13:0]} ^ badPar;
      end else if (hold != 4'h0) begin
         hold <= hold - 4'h1;
      end else begin
         // released bus keeps moving so no stale command is read
         cmdPins <= ~cmdPins;
      end
   end
endmodule

// File: mrf_mode_regs_tb.sv
// mrf_mode_regs_tb: self-checking bench for the mode register block
// assumes the controller model drives the command pins
`timescale 1ns/1ps
module mrf_mode_regs_tb
   import mrf_pkg::*;
;
   typedef struct packed {
      int          at;
      logic        perr;
      logic [21:0] m5;
      logic [21:0] m4;
      logic [7:0]  ohm;
      logic [2:0]  pl;
      logic [3:0]  cal;
      mrf_cmd_s    cmd;
   } mrf_note_s;
   logic core_clk = 1'b0, srst = 1'b1, cke = 1'b1, crcErr = 1'b0;
   logic mprRead = 1'b0, refreshReq = 1'b0, coolTemp = 1'b0;
   logic go = 1'b0, badPar = 1'b0, csN, parityIn, cmdAccept, parityErr;
   logic readInvEn, writeMaskEn, maxPowerSave, refreshDo;
   logic writeInvEn, odtBufOffPd, tcrEn, tcrExtended, vrefMon;
   logic [21:0] word = '0, mr5Value, mr4Value, m5 = '0, m4 = '0;
   logic [7:0]  parkOhm;
   logic [2:0]  parLatClk;
   logic [3:0]  calClk;
   mrf_cmd_s    cmdPins, cmdOut;
   int cyc = 0, refCnt = 0, mismatches = 0, total_checks = 0;
   int calTab [8] = '{0, 3, 4, 5, 6, 8, 0, 0};
   int ohmTab [8] = '{0, 60, 120, 40, 240, 48, 80, 34};
   mrf_note_s q [$];
   logic [2:0] m4Flags;

   assign m4Flags = {vrefMon, tcrEn, tcrExtended};

   always #25 core_clk = ~core_clk;

   mrf_ctrl_model i_mrf_ctrl_model (.core_clk(core_clk), .go(go),
      .word(word), .badPar(badPar), .csN(csN), .cmdPins(cmdPins),
      .parityIn(parityIn));
   mrf_mode_regs i_mrf_mode_regs (.core_clk(core_clk), .srst(srst),
      .csN(csN), .cke(cke), .cmdPins(cmdPins), .parityIn(parityIn),
      .crcErr(crcErr), .mprRead(mprRead), .refreshReq(refreshReq),
      .coolTemp(coolTemp), .mr5Value(mr5Value), .mr4Value(mr4Value),
      .cmdAccept(cmdAccept), .cmdOut(cmdOut), .parityErr(parityErr),
      .readInvEn(readInvEn), .writeInvEn(writeInvEn),
      .writeMaskEn(writeMaskEn), .parkOhm(parkOhm),
      .odtBufOffPd(odtBufOffPd), .parLatClk(parLatClk),
      .calClk(calClk), .tcrEn(tcrEn), .tcrExtended(tcrExtended),
      .vrefMon(vrefMon),
      .maxPowerSave(maxPowerSave), .refreshDo(refreshDo));

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic logic [21:0] mk(logic [2:0] s, logic [12:0] d);
      return {1'b0, s, 5'h00, d};
   endfunction

   // note keeps the expected register image when the command is taken
   task automatic mrs(logic [21:0] w, logic bad, logic note);
      mrf_note_s n;
      logic      on;
      @(posedge core_clk);
      if (note) begin
         on = bad && m5[2:0] != 3'h0 && (m5[9] || !m5[4]);
         n.at = cyc + calTab[m4[8:6]] + 3;
         if (on)
            m5[4] = 1'b1;
         else if (w[20:18] == 3'h5)
            m5 = (w & 22'h001FE7 & ~22'h18) | (m5 & w & 22'h18);
         else if (w[20:18] == 3'h4)
            m4 = w & 22'h0001DE;
         n.perr = on;
         n.m5 = m5;
         n.m4 = m4;
         n.ohm = 8'(ohmTab[m5[8:6]]);
         n.pl = (m5[2] == 1'b0 && m5[1:0] != 2'h0) ? m5[2:0] + 3'h3 : 3'h0;
         n.cal = 4'(calTab[m4[8:6]]);
         n.cmd = {1'b1, 3'h0, w[21:17], w[13:0]};
         q.push_back(n);
      end
      go <= 1'b1;
      word <= w;
      badPar <= bad;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (11) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         end_of_test();
      end
   end

   always @(negedge core_clk) begin
      if (refreshDo === 1'b1)
         refCnt++;
      if (cmdAccept === 1'b1 || parityErr === 1'b1) begin
         if (q.size() == 0) begin
            chk("unexpected", 1, 0);
         end else begin
            chk("time", cyc, q[0].at);
            chk("parErr", 32'(parityErr), 32'(q[0].perr));
            chk("mr5", 32'(mr5Value), 32'(q[0].m5));
            chk("mr4", 32'(mr4Value), 32'(q[0].m4));
            chk("park", 32'(parkOhm), 32'(q[0].ohm));
            chk("parLat", 32'(parLatClk), 32'(q[0].pl));
            chk("cal", 32'(calClk), 32'(q[0].cal));
            chk("rdInv", 32'(readInvEn), 32'(q[0].m5[12]));
            chk("wrInv", 32'(writeInvEn), 32'(q[0].m5[11]));
            chk("wrMask", 32'(writeMaskEn), 32'(q[0].m5[10]));
            chk("odtBuf", 32'(odtBufOffPd), 32'(q[0].m5[5]));
            chk("m4Bits", 32'(m4Flags), 32'(q[0].m4[4:2]));
            chk("cmdOut", 32'(cmdOut), 32'(q[0].cmd));
            void'(q.pop_front());
         end
      end
   end

   initial begin
      logic [12:0] d;
      void'($urandom(88263));
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      chk("rst5", 32'(mr5Value), 0);
      chk("rst4", 32'(mr4Value), 0);
      for (int k = 0; k < 8; k++)
         mrs(mk(3'h5, 13'((k << 6) | (k & 3))), 1'b0, 1'b1);
      @(posedge core_clk);
      crcErr <= 1'b1;
      @(posedge core_clk);
      crcErr <= 1'b0;
      m5[3] = 1'b1;
      @(negedge core_clk);
      chk("crc", 32'(mr5Value[3]), 1);
      mrs(mk(3'h5, 13'h1008), 1'b0, 1'b1);
      mprRead <= 1'b1;
      repeat (2) @(negedge core_clk);
      chk("mprInv", 32'(readInvEn), 0);
      mprRead <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         d = 13'($urandom());
         d[2] = 1'b0;
         if (d[11])
            d[10] = 1'b0;
         mrs(mk(3'h5, d), 1'b0, 1'b1);
      end
      mrs(mk(3'h5, 13'h0001), 1'b0, 1'b1);
      mrs(mk(3'h5, 13'h0003), 1'b1, 1'b1);
      mrs(mk(3'h5, 13'h0013), 1'b1, 1'b1);
      mrs(mk(3'h5, 13'h0211), 1'b1, 1'b1);
      mrs(mk(3'h5, 13'h0201), 1'b1, 1'b1);
      // parity off and status cleared before the latency runs
      mrs(mk(3'h5, 13'h0000), 1'b0, 1'b1);
      mrs(mk(3'h6, 13'h1FFF), 1'b0, 1'b1);
      for (int k = 1; k < 7; k++)
         mrs(mk(3'h4, 13'((k % 6) << 6)), 1'b0, 1'b1);
      mrs(mk(3'h4, 13'h001C), 1'b0, 1'b1);
      coolTemp <= 1'b1;
      refCnt = 0;
      repeat (4) begin
         refreshReq <= 1'b1;
         @(posedge core_clk);
         refreshReq <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      chk("tcr", refCnt, 2);
      mrs(mk(3'h4, 13'h0002), 1'b0, 1'b1);
      chk("mps", 32'(maxPowerSave), 1);
      mrs(mk(3'h5, 13'h1000), 1'b0, 1'b0);
      cke <= 1'b0;
      @(posedge core_clk);
      cke <= 1'b1;
      repeat (3) @(posedge core_clk);
      m4[1] = 1'b0;
      chk("mpsExit", 32'(maxPowerSave), 0);
      mrs(mk(3'h5, 13'h1000), 1'b0, 1'b1);
      chk("pending", q.size(), 0);
      end_of_test();
   end
endmodule
